// ### src/serial_port_pkg.sv
package serial_port_pkg;
   // ----------------------------------------
   // Operating modes and state encodings
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_BOOT} port_mode_e;
   typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH} eng_state_e;
   typedef enum logic [1:0] {BOOT_IDLE, BOOT_CMD, BOOT_READ, BOOT_DONE} boot_state_e;

   // ----------------------------------------
   // Straps and boot sequence
   // ----------------------------------------
   localparam int STRAP_W = 2;
   localparam logic [STRAP_W-1:0] BOOT_STRAP = 2'h1;  // Strap code that selects booting
   localparam logic [1:0] STRAP_WAIT = 2'h3;          // Edges after release before capture
   localparam logic [31:0] BOOT_CMD_WORD = 32'h03000000;  // Read command, address zero
   localparam logic [5:0] BOOT_BITS = 6'h20;           // Bits per boot transfer
   localparam logic [4:0] BOOT_WORDS = 5'h10;          // Words loaded before release
   localparam logic [7:0] BOOT_HALF_DIV = 8'h04;       // Half period of boot clock, less one core cycle
   localparam logic [7:0] MIN_HALF = 8'h04;            // Covers the data input synchroniser

   // ----------------------------------------
   // Slave frame layout, counted in link clock edges
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int REG_WORDS = 16;
   localparam int CMD_WR_BIT = 7;
   localparam logic [5:0] CMD_LAST = 6'h07;
   localparam logic [5:0] WDATA_LAST = 6'h27;
   localparam logic [5:0] RD_LOAD = 6'h10;
   localparam logic [5:0] RD_END = 6'h30;
   localparam logic [5:0] CNT_MAX = 6'h3f;

   // Shift one serial bit in at the low end, MSB first on the wire
   function automatic logic [31:0] shift_in(input logic [31:0] word, input logic bit_in);
      shift_in = {word[30:0], bit_in};
   endfunction : shift_in
endpackage : serial_port_pkg

// ### src/slave_link_if.sv
`timescale 1ns/1ps
// Link-domain slave engine to core crossing
interface slave_link_if;
   logic wr_tgl;          // Toggles once per completed write
   logic rd_tgl;          // Toggles once per read command
   logic [3:0] addr;      // Register index, stable after toggle
   logic [31:0] wdata;    // Write word, stable after toggle
   logic [31:0] rdata;    // Read word from core, stable long before use
   logic core_rst_b;      // Core reset; the crossing flops must outlive a frame
   modport link(output wr_tgl, output rd_tgl, output addr, output wdata, input rdata, input core_rst_b);
   modport core(input wr_tgl, input rd_tgl, input addr, input wdata, output rdata, output core_rst_b);
endinterface : slave_link_if

// ### src/slave_link.sv
`timescale 1ns/1ps
module slave_link import serial_port_pkg::*; (
   // Link clock and frame reset
   input logic sclk,
   input logic link_rst_b,
   // Serial pins
   input logic din,
   output logic dout,
   output logic dout_oe,
   // Core side
   slave_link_if.link bus
);
   // ----------------------------------------
   // Receive side, rising edge
   // ----------------------------------------
   logic [5:0] cnt_reg, cnt_next;        // Edges seen in this frame
   logic [31:0] in_sh_reg, in_sh_next;   // Incoming bits
   logic [7:0] cmd_reg, cmd_next;        // Command byte
   logic [3:0] addr_reg, addr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wr_tgl_reg, wr_tgl_next;
   logic rd_tgl_reg, rd_tgl_next;

   // Decode the frame as it arrives
   always_comb begin
      cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;
      in_sh_next = shift_in(in_sh_reg, din);
      cmd_next = cmd_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      wr_tgl_next = wr_tgl_reg;
      rd_tgl_next = rd_tgl_reg;
      if (cnt_reg == CMD_LAST) begin
         cmd_next = in_sh_next[7:0];
         addr_next = in_sh_next[ADDR_W-1:0];
         // Reads ask the core early; eight dummy bits give it time
         if (!in_sh_next[CMD_WR_BIT]) begin
            rd_tgl_next = ~rd_tgl_reg;
         end
      end
      if (cnt_reg == WDATA_LAST && cmd_reg[CMD_WR_BIT]) begin
         wdata_next = in_sh_next;
         wr_tgl_next = ~wr_tgl_reg;
      end
   end

   // Select high clears the frame through link_rst_b
   always_ff @(posedge sclk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         cnt_reg <= 6'h00;
         in_sh_reg <= 32'h0;
         cmd_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
         in_sh_reg <= in_sh_next;
         cmd_reg <= cmd_next;
      end
   end

   // Crossing flops reset with the core only: a toggle cleared by select would look like a new request
   always_ff @(posedge sclk or negedge bus.core_rst_b) begin
      if (!bus.core_rst_b) begin
         addr_reg <= 4'h0;
         wdata_reg <= 32'h0;
         wr_tgl_reg <= 1'b0;
         rd_tgl_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         wr_tgl_reg <= wr_tgl_next;
         rd_tgl_reg <= rd_tgl_next;
      end
   end

   // ----------------------------------------
   // Transmit side, falling edge
   // ----------------------------------------
   logic [31:0] out_sh_reg, out_sh_next;
   logic oe_reg, oe_next;

   // Read word goes out MSB first, then the pin floats again
   always_comb begin
      out_sh_next = out_sh_reg;
      oe_next = oe_reg;
      if (cnt_reg == RD_LOAD && !cmd_reg[CMD_WR_BIT]) begin
         out_sh_next = bus.rdata;
         oe_next = 1'b1;
      end else if (oe_reg && cnt_reg == RD_END) begin
         oe_next = 1'b0;
      end else if (oe_reg) begin
         out_sh_next = {out_sh_reg[30:0], 1'b0};
      end
   end

   always_ff @(negedge sclk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         out_sh_reg <= 32'h0;
         oe_reg <= 1'b0;
      end else begin
         out_sh_reg <= out_sh_next;
         oe_reg <= oe_next;
      end
   end

   assign dout = out_sh_reg[31];
   assign dout_oe = oe_reg;
   assign bus.wr_tgl = wr_tgl_reg;
   assign bus.rd_tgl = rd_tgl_reg;
   assign bus.addr = addr_reg;
   assign bus.wdata = wdata_reg;

   a_slave_read_out: assert property (
      @(negedge sclk) disable iff (!link_rst_b)
      (cnt_reg == RD_LOAD && !cmd_reg[CMD_WR_BIT]) |=> (oe_reg && out_sh_reg == $past(bus.rdata)))
      else $error("slave read word not driven");
endmodule : slave_link

// ### src/serial_cpu_port_modes.sv
`timescale 1ns/1ps
module serial_cpu_port_modes import serial_port_pkg::*; (
   // Core clock and reset
   input logic clk,
   input logic rst_b,
   // Serial clock pin and link clock
   input logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   // Serial data pins
   input logic serial_port_data_in,
   output logic serial_port_data_out,
   output logic serial_port_data_oe,
   // Select pin
   input logic port_select_n_in,
   output logic port_select_n_out,
   output logic port_select_n_oe,
   // Straps
   input logic [1:0] boot_config_straps,
   // Master transfer port
   input logic master_enable,
   input logic mst_start,
   input logic [5:0] mst_bits,
   input logic [7:0] mst_half_div,
   input logic [31:0] mst_wdata,
   output logic mst_busy,
   output logic mst_done,
   output logic [31:0] mst_rdata,
   // Boot data port
   output logic [31:0] boot_word,
   output logic boot_word_valid,
   output logic boot_done
);
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   slave_link_if bus ();
   logic din_s1, din_s2;
   logic [1:0] straps_s1, straps_s2;
   logic wr_s1, wr_s2, wr_s3;
   logic rd_s1, rd_s2, rd_s3;
   logic wr_evt, rd_evt;

   // Data and strap pins and link toggles pass two flops before use; the select pin feeds the frame reset directly
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
         straps_s1 <= 2'h0;
         straps_s2 <= 2'h0;
         {wr_s1, wr_s2, wr_s3} <= 3'h0;
         {rd_s1, rd_s2, rd_s3} <= 3'h0;
      end else begin
         din_s1 <= serial_port_data_in;
         din_s2 <= din_s1;
         straps_s1 <= boot_config_straps;
         straps_s2 <= straps_s1;
         {wr_s1, wr_s2, wr_s3} <= {bus.wr_tgl, wr_s1, wr_s2};
         {rd_s1, rd_s2, rd_s3} <= {bus.rd_tgl, rd_s1, rd_s2};
      end
   end

   assign wr_evt = wr_s2 ^ wr_s3;
   assign rd_evt = rd_s2 ^ rd_s3;

   // ----------------------------------------
   // Register file reached by the slave
   // ----------------------------------------
   logic [31:0] mem [REG_WORDS];  // No reset; contents are software's
   logic [31:0] rd_word_reg, rd_word_next;

   // Writes land once the toggle has crossed
   always_ff @(posedge clk) begin
      if (wr_evt) begin
         mem[bus.addr] <= bus.wdata;
      end
   end

   // Read word is held until the next read request
   always_comb begin
      rd_word_next = rd_evt ? mem[bus.addr] : rd_word_reg;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_word_reg <= 32'h0;
      end else begin
         rd_word_reg <= rd_word_next;
      end
   end

   assign bus.rdata = rd_word_reg;
   assign bus.core_rst_b = rst_b;

   // ----------------------------------------
   // Mode, boot sequencer and shift engine
   // ----------------------------------------
   port_mode_e mode_reg, mode_next;
   boot_state_e boot_state_reg, boot_state_next;
   eng_state_e eng_state_reg, eng_state_next;
   logic strap_done_reg, strap_done_next;
   logic [1:0] wait_reg, wait_next;
   logic [4:0] boot_cnt_reg, boot_cnt_next;
   logic [7:0] eng_cnt_reg, eng_cnt_next;     // Half period countdown
   logic [7:0] eng_half_reg, eng_half_next;
   logic [5:0] eng_bits_reg, eng_bits_next;   // Bits still to move
   logic [31:0] eng_sh_reg, eng_sh_next;
   logic sclk_reg, sclk_next;
   logic do_reg, do_next;
   logic do_oe_reg, do_oe_next;
   logic cs_reg, cs_next;
   logic drive_reg, drive_next;               // Clock and select oe
   logic busy_reg, busy_next;
   logic mst_done_reg, mst_done_next;
   logic [31:0] mst_rdata_reg, mst_rdata_next;
   logic [31:0] boot_word_reg, boot_word_next;
   logic boot_valid_reg, boot_valid_next;
   logic boot_done_reg, boot_done_next;
   logic go;                                  // Load the engine this cycle
   logic [31:0] go_data;
   logic [5:0] go_bits;
   logic [7:0] go_half;
   logic eng_done;
   logic [31:0] eng_word;
   port_mode_e run_mode;

   // Everything in the core domain steps together
   always_comb begin
      mode_next = mode_reg;
      boot_state_next = boot_state_reg;
      eng_state_next = eng_state_reg;
      strap_done_next = strap_done_reg;
      wait_next = wait_reg;
      boot_cnt_next = boot_cnt_reg;
      eng_cnt_next = eng_cnt_reg;
      eng_half_next = eng_half_reg;
      eng_bits_next = eng_bits_reg;
      eng_sh_next = eng_sh_reg;
      sclk_next = sclk_reg;
      mst_done_next = 1'b0;
      mst_rdata_next = mst_rdata_reg;
      boot_word_next = boot_word_reg;
      boot_valid_next = 1'b0;
      boot_done_next = boot_done_reg;
      go = 1'b0;
      go_data = 32'h0;
      go_bits = BOOT_BITS;
      go_half = BOOT_HALF_DIV;
      eng_word = shift_in(eng_sh_reg, din_s2);
      eng_done = (eng_state_reg == ENG_HIGH) && (eng_cnt_reg == 8'h00) && (eng_bits_reg == 6'h01);
      run_mode = master_enable ? MODE_MASTER : MODE_SLAVE;
      // Straps are taken a few edges after release, once settled
      if (!strap_done_reg) begin
         if (wait_reg == STRAP_WAIT) begin
            strap_done_next = 1'b1;
            if (straps_s2 == BOOT_STRAP) begin
               mode_next = MODE_BOOT;
               boot_state_next = BOOT_CMD;
               go = 1'b1;
               go_data = BOOT_CMD_WORD;
            end else begin
               mode_next = run_mode;
            end
         end else begin
            wait_next = wait_reg + 2'h1;
         end
      end else if (mode_reg != MODE_BOOT && eng_state_reg == ENG_IDLE) begin
         // Mode only changes between transfers
         mode_next = run_mode;
      end
      unique case (boot_state_reg)
         BOOT_CMD: begin
            if (eng_done) begin
               boot_state_next = BOOT_READ;
               go = 1'b1;  // Zeros out while data comes in
            end
         end
         BOOT_READ: begin
            if (eng_done) begin
               boot_word_next = eng_word;
               boot_valid_next = 1'b1;
               if (boot_cnt_reg == BOOT_WORDS - 5'h01) begin
                  boot_state_next = BOOT_DONE;
                  boot_done_next = 1'b1;
                  mode_next = run_mode;
               end else begin
                  boot_cnt_next = boot_cnt_reg + 5'h01;
                  go = 1'b1;
               end
            end
         end
         BOOT_IDLE, BOOT_DONE: begin
            if (eng_done) begin
               mst_done_next = 1'b1;
               mst_rdata_next = eng_word;
            end
            if (mode_reg == MODE_MASTER && eng_state_reg == ENG_IDLE && mst_start) begin
               go = 1'b1;
               go_data = mst_wdata;
               go_bits = (mst_bits == 6'h00 || mst_bits > BOOT_BITS) ? BOOT_BITS : mst_bits;
               // Short half periods would outrun the input synchroniser
               go_half = (mst_half_div < MIN_HALF) ? MIN_HALF : mst_half_div;
            end
         end
      endcase
      // Data changes on the falling edge, input sampled at the end of the high half as the clock falls
      unique case (eng_state_reg)
         ENG_IDLE: begin
         end
         ENG_LOW: begin
            if (eng_cnt_reg == 8'h00) begin
               eng_state_next = ENG_HIGH;
               eng_cnt_next = eng_half_reg;
               sclk_next = 1'b1;
            end else begin
               eng_cnt_next = eng_cnt_reg - 8'h01;
            end
         end
         ENG_HIGH: begin
            if (eng_cnt_reg == 8'h00) begin
               eng_sh_next = eng_word;
               sclk_next = 1'b0;
               eng_cnt_next = eng_half_reg;
               eng_bits_next = eng_bits_reg - 6'h01;
               eng_state_next = (eng_bits_reg == 6'h01) ? ENG_IDLE : ENG_LOW;
            end else begin
               eng_cnt_next = eng_cnt_reg - 8'h01;
            end
         end
      endcase
      // A load may follow a finish in the same cycle, so boot runs gapless
      if (go) begin
         eng_state_next = ENG_LOW;
         eng_sh_next = go_data;
         eng_bits_next = go_bits;
         eng_half_next = go_half;
         eng_cnt_next = go_half;
         sclk_next = 1'b0;
      end
      do_next = eng_sh_next[31];
      do_oe_next = (eng_state_next != ENG_IDLE);
      busy_next = (mode_next == MODE_MASTER) && (eng_state_next != ENG_IDLE);
      cs_next = !(busy_next || boot_state_next == BOOT_CMD || boot_state_next == BOOT_READ);
      drive_next = (mode_next != MODE_SLAVE);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= MODE_SLAVE;
         boot_state_reg <= BOOT_IDLE;
         eng_state_reg <= ENG_IDLE;
         strap_done_reg <= 1'b0;
         wait_reg <= 2'h0;
         boot_cnt_reg <= 5'h00;
         eng_cnt_reg <= 8'h00;
         eng_half_reg <= BOOT_HALF_DIV;
         eng_bits_reg <= 6'h00;
         eng_sh_reg <= 32'h0;
         sclk_reg <= 1'b0;
         do_reg <= 1'b0;
         do_oe_reg <= 1'b0;
         cs_reg <= 1'b1;
         drive_reg <= 1'b0;
         busy_reg <= 1'b0;
         mst_done_reg <= 1'b0;
         mst_rdata_reg <= 32'h0;
         boot_word_reg <= 32'h0;
         boot_valid_reg <= 1'b0;
         boot_done_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         boot_state_reg <= boot_state_next;
         eng_state_reg <= eng_state_next;
         strap_done_reg <= strap_done_next;
         wait_reg <= wait_next;
         boot_cnt_reg <= boot_cnt_next;
         eng_cnt_reg <= eng_cnt_next;
         eng_half_reg <= eng_half_next;
         eng_bits_reg <= eng_bits_next;
         eng_sh_reg <= eng_sh_next;
         sclk_reg <= sclk_next;
         do_reg <= do_next;
         do_oe_reg <= do_oe_next;
         cs_reg <= cs_next;
         drive_reg <= drive_next;
         busy_reg <= busy_next;
         mst_done_reg <= mst_done_next;
         mst_rdata_reg <= mst_rdata_next;
         boot_word_reg <= boot_word_next;
         boot_valid_reg <= boot_valid_next;
         boot_done_reg <= boot_done_next;
      end
   end

   // ----------------------------------------
   // Slave engine on the external clock
   // ----------------------------------------
   logic slave_rst_b;
   logic slv_dout, slv_dout_oe;

   // Frame lives only while selected in slave mode
   assign slave_rst_b = rst_b & (mode_reg == MODE_SLAVE) & ~port_select_n_in;

   slave_link u_slave (
      .sclk(sclk_in),
      .link_rst_b(slave_rst_b),
      .din(serial_port_data_in),
      .dout(slv_dout),
      .dout_oe(slv_dout_oe),
      .bus(bus.link)
   );

   // ----------------------------------------
   // Pin outputs
   // ----------------------------------------
   // Data pin selects between two flop sources by mode
   assign serial_port_data_out = (mode_reg == MODE_SLAVE) ? slv_dout : do_reg;
   assign serial_port_data_oe = (mode_reg == MODE_SLAVE) ? slv_dout_oe : do_oe_reg;
   assign sclk_out = sclk_reg;
   assign sclk_oe = drive_reg;
   assign port_select_n_out = cs_reg;
   assign port_select_n_oe = drive_reg;
   assign mst_busy = busy_reg;
   assign mst_done = mst_done_reg;
   assign mst_rdata = mst_rdata_reg;
   assign boot_word = boot_word_reg;
   assign boot_word_valid = boot_valid_reg;
   assign boot_done = boot_done_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_mst_start;
      mode_reg == MODE_MASTER && eng_state_reg == ENG_IDLE && mst_start;
   endsequence

   sequence s_boot_begin;
      boot_state_reg == BOOT_CMD && $past(boot_state_reg) == BOOT_IDLE;
   endsequence

   a_slave_clk_in: assert property (
      mode_reg == MODE_SLAVE && $past(mode_reg) == MODE_SLAVE |-> !sclk_oe && !port_select_n_oe)
      else $error("clock driven in slave mode");
   a_master_clk_out: assert property (
      mode_reg != MODE_SLAVE && $past(mode_reg) != MODE_SLAVE |-> sclk_oe)
      else $error("clock not driven as master");
   a_din_sampled: assert property (
      eng_state_reg == ENG_HIGH && eng_cnt_reg == 8'h00 && !go |=> eng_sh_reg[0] == $past(din_s2))
      else $error("input bit not sampled");
   a_select_access: assert property (
      mode_reg == MODE_MASTER && eng_state_reg != ENG_IDLE |-> !port_select_n_out)
      else $error("select high during master access");
   a_boot_select: assert property (
      (boot_state_reg == BOOT_READ |-> !port_select_n_out) and ($rose(boot_done) |-> port_select_n_out))
      else $error("boot select wrong");
   a_boot_strap: assert property (
      mode_reg == MODE_BOOT && $past(mode_reg) != MODE_BOOT |-> $past(straps_s2) == BOOT_STRAP)
      else $error("boot without strap");
   a_reg_write: assert property (
      wr_evt |=> mem[$past(bus.addr)] == $past(bus.wdata))
      else $error("slave write lost");
   a_master_load: assert property (
      s_mst_start |=> eng_state_reg == ENG_LOW && !sclk_out && !port_select_n_out
         && eng_sh_reg == $past(mst_wdata))
      else $error("master transfer not started");
   a_boot_command: assert property (
      s_boot_begin |-> eng_sh_reg == BOOT_CMD_WORD && do_oe_reg && do_reg == BOOT_CMD_WORD[31])
      else $error("boot command not sent");
   a_dout_quiet: assert property (
      mode_reg != MODE_SLAVE && eng_state_reg == ENG_IDLE |-> !serial_port_data_oe)
      else $error("data pin driven while idle");
endmodule : serial_cpu_port_modes

// ### verification/far_side_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side peripheral and boot memory
// ----------------------------------------
module far_side_model (
   // Pins
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   output logic miso,
   // Bench view
   input wire logic [31:0] pattern,
   output logic [9:0] rises,
   output logic [31:0] heard,
   output logic [31:0] cmd
);
   logic fresh; // Next rise opens a frame
   logic [9:0] idx; // Bit index of this rise
   assign idx = fresh ? 10'h0 : rises;
   initial begin
      fresh = 1'b1;
      miso = 1'b0;
   end
   // Answer moves after a rise, so it is settled at the device's sampling fall
   always @(posedge sclk or posedge sel_n) begin
      if (sel_n) begin
         fresh <= 1'b1;
         miso <= ~miso; // Released: never shows the last bit
      end else begin
         fresh <= 1'b0;
         rises <= idx + 10'h1;
         miso <= pattern[~idx[4:0]];
         heard <= {fresh ? 31'h0 : heard[30:0], mosi};
         if (idx == 10'h1f) begin
            cmd <= {heard[30:0], mosi};
         end
      end
   end
endmodule : far_side_model

// ### verification/serial_cpu_port_modes_tb.sv
`timescale 1ns/1ps
module serial_cpu_port_modes_tb import serial_port_pkg::*; ;
   // ----------------------------------------
   // Stimulus, pins and bookkeeping
   // ----------------------------------------
   logic clk, rst_b, sclk_m, sel_m, din_m, master_enable, mst_start, bad;
   logic [1:0] straps;
   logic [3:0] a;
   logic [5:0] mst_bits;
   logic [7:0] mst_half_div;
   logic [31:0] mst_wdata, pattern, seed, rd, wd, mst_rdata, boot_word, heard, cmd;
   logic sclk_out, sclk_oe, dout, dout_oe, sel_out, sel_oe, mst_busy, mst_done, miso, bwv, boot_done;
   logic [9:0] rises;
   logic [31:0] exp_q[$], msk_q[$]; // Expected word and mask of valid bits
   int errors, samples_checked, b, h, hr, n;
   // Pins resolved from enables; released select floats high
   wire sclk_pin = sclk_oe ? sclk_out : sclk_m;
   wire sel_pin = sel_oe ? sel_out : sel_m;
   wire din_pin = sclk_oe ? miso : din_m;
   serial_cpu_port_modes i_dut (.clk(clk), .rst_b(rst_b), .sclk_in(sclk_pin), .sclk_out(sclk_out),
      .sclk_oe(sclk_oe), .serial_port_data_in(din_pin), .serial_port_data_out(dout),
      .serial_port_data_oe(dout_oe), .port_select_n_in(sel_pin), .port_select_n_out(sel_out),
      .port_select_n_oe(sel_oe), .boot_config_straps(straps), .master_enable(master_enable),
      .mst_start(mst_start), .mst_bits(mst_bits), .mst_half_div(mst_half_div), .mst_wdata(mst_wdata),
      .mst_busy(mst_busy), .mst_done(mst_done), .mst_rdata(mst_rdata), .boot_word(boot_word),
      .boot_word_valid(bwv), .boot_done(boot_done));
   far_side_model i_far (.sclk(sclk_pin), .sel_n(sel_pin), .mosi(dout), .miso(miso), .pattern(pattern),
      .rises(rises), .heard(heard), .cmd(cmd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check32(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : check32
   task automatic complete_run;
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task automatic do_reset(input logic [1:0] s);
      rst_b = 1'b0;
      straps = s;
      repeat (3) @(posedge clk);
      #2 rst_b = 1'b1;
   endtask : do_reset
   // External master frame; the link clock only runs inside it
   task automatic frame(input logic [7:0] c, input logic [31:0] w, input int cnt, output logic [31:0] r);
      logic [39:0] tx;
      tx = {c, w};
      r = 32'h0;
      #7 sel_m = 1'b0;
      for (int i = 0; i < cnt; i++) begin
         din_m = (i < 40) ? tx[39 - i] : ~din_m;
         #40 sclk_m = 1'b1;
         if (i > 15) r = {r[30:0], dout_oe ? dout : 1'bx};
         #40 sclk_m = 1'b0;
      end
      #40 sel_m = 1'b1;
      #400;
   endtask : frame
   // ----------------------------------------
   // Monitor: each received word takes the oldest note
   // ----------------------------------------
   always @(posedge clk) begin
      #1;
      if (bwv === 1'b1 || mst_done === 1'b1) begin
         check32("rx word", exp_q[0], (mst_done === 1'b1 ? mst_rdata : boot_word) & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // Boot takes about 140 us, the rest well under that again
   initial begin
      #1000000;
      errors++;
      complete_run();
   end
   initial begin
      seed = 32'h0bb7;
      errors = 0;
      samples_checked = 0;
      {sclk_m, din_m, master_enable, mst_start, mst_half_div, mst_wdata} = '0;
      sel_m = 1'b1;
      mst_bits = 6'h20;
      pattern = $random(seed);
      for (int k = 0; k < 16; k++) begin
         exp_q.push_back(pattern);
         msk_q.push_back(32'hffffffff);
      end
      // Boot from straps, one long select-low frame
      do_reset(2'h1);
      repeat (8000) begin
         if (boot_done === 1'b1) break;
         @(posedge clk);
      end
      #2;
      check32("boot command", BOOT_CMD_WORD, cmd);
      check32("boot clocks", 32'h220, {22'h0, rises});
      check32("boot release", 32'h0, {31'h0, sel_oe});
      // Other strap code, mid-run reset: no boot
      do_reset(2'h2);
      repeat (20) @(posedge clk);
      check32("no boot", 32'h0, {30'h0, sclk_oe, sel_oe});
      // Slave: write, aborted overwrite, read back
      for (int k = 0; k < 3; k++) begin
         wd = $random(seed);
         a = 4'($random(seed));
         frame({4'h8, a}, wd, 40, rd);
         frame({4'h8, a}, ~wd, 20, rd);
         frame({4'h0, a}, $random(seed), 48, rd);
         check32("slave read", wd, rd);
         check32("idle data", 32'h0, {31'h0, dout_oe});
      end
      // Master: boundary and random lengths, back to back
      master_enable = 1'b1;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         b = (k == 0) ? 1 : (k == 3) ? 32 : 1 + ($unsigned($random(seed)) % 32);
         hr = $unsigned($random(seed)) % 8;
         h = (hr < 4) ? 4 : hr;
         @(posedge clk);
         #2;
         mst_bits = 6'(b % 32); // A full word goes as code zero
         mst_half_div = 8'(hr);
         mst_wdata = $random(seed);
         pattern = $random(seed);
         mst_start = 1'b1;
         exp_q.push_back(pattern >> (32 - b));
         msk_q.push_back(32'hffffffff >> (32 - b));
         @(posedge clk);
         n = 0;
         bad = 1'b0;
         do begin
            @(posedge clk);
            #2;
            n++;
            mst_start = 1'b0; // Held into busy, must be ignored
            if (mst_busy === 1'b1 && sel_pin !== 1'b0) bad = 1'b1;
         end while (mst_done !== 1'b1 && n < 3000);
         check32("master time", 2 * b * (h + 1), n);
         check32("master sent", mst_wdata >> (32 - b), heard & (32'hffffffff >> (32 - b)));
         check32("master clocks", b, {22'h0, rises});
         check32("master select", 32'h0, {31'h0, bad});
      end
      check32("notes left", 32'h0, exp_q.size());
      complete_run();
   end
endmodule : serial_cpu_port_modes_tb
